/* core/hls_pkg.sv */
// package for the halt and light idle standby controller
// assumes one pclk domain and an apb master on the register side
package hls_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] HLS_OFS_PSC    = 8'h00;
  localparam logic [7:0] HLS_OFS_MODE   = 8'h04;
  localparam logic [7:0] HLS_OFS_STATUS = 8'h08;
  // ==========================================================
  // power save control fields
  localparam int HLS_PSC_WDT_MASK = 6;
  localparam int HLS_PSC_NMI_MASK = 5;
  localparam int HLS_PSC_INT_MASK = 4;
  localparam int HLS_PSC_STP      = 1;
  localparam logic [7:0] HLS_PSC_RST  = 8'h00;
  localparam logic [7:0] HLS_PSC_WMSK = 8'h72;
  // ==========================================================
  // mode select fields
  localparam logic [1:0] HLS_KIND_LIGHT = 2'h0;
  localparam logic [1:0] HLS_MODE_RST   = 2'h0;
  // ==========================================================
  // widths
  localparam int HLS_N_PIN  = 11;
  localparam int HLS_N_PER  = 8;
  localparam int HLS_N_RST  = 5;
  localparam int HLS_PRIO_W = 3;
  // ==========================================================
  // controller states
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_IDLE = 2'b10,
    ST_WAKE = 2'b11
  } hls_state_t;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic                  nmi_pin;
    logic                  wdt;
    logic                  maskable;
    logic [HLS_PRIO_W-1:0] pend_prio;
    logic [HLS_PRIO_W-1:0] serv_prio;
    logic                  in_service;
    logic                  irq_en;
  } hls_wake_t;
  typedef struct packed {
    logic cpu;
    logic periph;
    logic dma;
    logic timer_m;
    logic watch;
    logic subclk_periph;
    logic osc_pll_flash;
  } hls_clk_en_t;
  typedef struct packed {
    logic nmi;
    logic from_wdt;
    logic ack;
    logic next;
  } hls_action_t;
endpackage : hls_pkg

/* core/hls_sync.sv */
// two flop synchroniser for asynchronous levels
// assumes inputs come from pins or other clock sources
`timescale 1ns/100ps
module hls_sync
  import hls_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // ==========================================================
  // stages
  logic [W-1:0] meta_reg;
  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : hls_sync

/* core/hls_wake_eval.sv */
// wake decision for the halt and light idle states
// assumes synchronised requests and priorities from the interrupt controller
`timescale 1ns/100ps
module hls_wake_eval
  import hls_pkg::*;
(
  // requests
  input  wire hls_wake_t   req,
  // state and masks
  input  wire logic        in_idle,
  input  wire logic        wdt_mask,
  input  wire logic        nmi_mask,
  input  wire logic        int_mask,
  // decision
  output logic             wake,
  output hls_action_t      act
);
  // ==========================================================
  // qualification
  logic nmi_ok;
  logic wdt_ok;
  logic msk_ok;
  logic higher;
  // masks only count in light idle, never in halt
  assign nmi_ok = req.nmi_pin & ~(in_idle & nmi_mask);
  assign wdt_ok = req.wdt & ~(in_idle & wdt_mask);
  assign msk_ok = req.maskable & ~(in_idle & int_mask);
  // any qualified source wakes, priority plays no part
  assign wake = nmi_ok | wdt_ok | msk_ok;
  // lower code means higher priority
  assign higher = ~req.in_service | (req.pend_prio < req.serv_prio);
  always_comb
  begin
    act = '0;
    if (nmi_ok | wdt_ok)
    begin
      act.nmi      = 1'b1;
      act.from_wdt = ~nmi_ok & wdt_ok;
    end
    else if (msk_ok && req.irq_en && higher)
      act.ack = 1'b1;
    else if (msk_ok)
      act.next = 1'b1;
  end
endmodule : hls_wake_eval

/* core/hls_standby_ctrl.sv */
// halt and light idle standby controller with apb registers
// assumes cpu, interrupt controller and peripherals share pclk;
// pins and reset sources are asynchronous and are synchronised here
//
// Summary of operation
// - halt instruction gates cpu clock, and timer m and watch clocks set to an unused subclock
// - pending request at halt wakes at once
// - nmi, pin, peripheral irq or reset ends halt
// - any qualified request wakes, priority ignored
// - lower priority wake stays pending, unacknowledged
// - higher priority or nmi wake is acknowledged
// - nmi wake branches to its handler
// - maskable wake vectors if enabled, else continues
// - reset from standby equals ordinary reset
// - halt keeps data, ports hold their state
// - halt keeps dma, timers, serial, converter running
// - watch timer runs on baud clock or subclock
// - wake masks ignored when leaving halt
// - kind 00 then stop bit enters light idle
// - light idle gates cpu, peripherals and dma
// - subclock and external clock peripherals keep running
// - no stabilisation wait leaving light idle
// - pending request at idle entry wakes at once
// - nmi, pin, peripheral irq or reset ends idle
// - masked wake class cannot end light idle
`timescale 1ns/100ps
module hls_standby_ctrl
  import hls_pkg::*;
(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // cpu side
  input  wire logic                  cpu_halt_exec,
  input  wire logic                  irq_enabled_state,
  // interrupt sources
  input  wire logic                  nmi_pin,
  input  wire logic                  watchdog_overflow_irq,
  input  wire logic [HLS_N_PIN-1:0]  external_pin_irqs,
  input  wire logic [HLS_N_PIN-1:0]  pin_irq_unmask,
  input  wire logic [HLS_N_PER-1:0]  periph_irqs,
  input  wire logic [HLS_N_PER-1:0]  periph_irq_unmask,
  input  wire logic [HLS_PRIO_W-1:0] pend_prio,
  input  wire logic [HLS_PRIO_W-1:0] serv_prio,
  input  wire logic                  in_service,
  // reset sources, asynchronous
  input  wire logic                  reset_pin_n,
  input  wire logic                  watchdog_reset_req,
  input  wire logic                  power_on_clear,
  input  wire logic                  low_voltage_detect,
  input  wire logic                  clock_monitor_reset,
  // clock selections
  input  wire logic                  subclock_used,
  input  wire logic                  tmm_clk_is_subclk,
  input  wire logic                  tmm_clk_is_intosc,
  input  wire logic                  watch_clk_is_baud,
  // clock enables and retention
  output hls_clk_en_t                clk_en,
  output logic                       port_hold,
  output logic                       ram_retain,
  output logic                       sys_reset_req,
  // resume actions, one cycle pulses
  output hls_action_t                resume
);
  // ==========================================================
  // synchronisers
  logic [HLS_N_PIN:0]   pins_s;
  logic [HLS_N_RST-1:0] rst_s;
  hls_sync #(.W(HLS_N_PIN + 1)) u_sync_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({nmi_pin, external_pin_irqs}),
    .sync_out (pins_s)
  );
  hls_sync #(.W(HLS_N_RST)) u_sync_rst (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({~reset_pin_n, watchdog_reset_req, power_on_clear,
                low_voltage_detect, clock_monitor_reset}),
    .sync_out (rst_s)
  );
  // ==========================================================
  // reset sources
  logic soft_rst;
  // every source takes the normal reset path, in standby or not
  assign soft_rst = |rst_s;
  // ==========================================================
  // state and registers
  hls_state_t  state_reg;
  hls_state_t  state_next;
  logic [7:0]  psc_reg;
  logic [1:0]  mode_reg;
  hls_action_t act_reg;
  hls_action_t last_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  // ==========================================================
  // wake evaluation
  hls_wake_t   wreq;
  hls_action_t act_c;
  logic        wake_c;
  logic        in_idle;
  logic        in_stby;
  assign wreq.nmi_pin    = pins_s[HLS_N_PIN];
  assign wreq.wdt        = watchdog_overflow_irq;
  assign wreq.maskable   = |(pins_s[HLS_N_PIN-1:0] & pin_irq_unmask) |
                           |(periph_irqs & periph_irq_unmask);
  assign wreq.pend_prio  = pend_prio;
  assign wreq.serv_prio  = serv_prio;
  assign wreq.in_service = in_service;
  assign wreq.irq_en     = irq_enabled_state;
  assign in_idle = (state_reg == ST_IDLE);
  assign in_stby = (state_reg == ST_HALT) | in_idle;
  // evaluated on pclk, which the oscillator keeps running
  hls_wake_eval u_wake (
    .req      (wreq),
    .in_idle  (in_idle),
    .wdt_mask (psc_reg[HLS_PSC_WDT_MASK]),
    .nmi_mask (psc_reg[HLS_PSC_NMI_MASK]),
    .int_mask (psc_reg[HLS_PSC_INT_MASK]),
    .wake     (wake_c),
    .act      (act_c)
  );
  // ==========================================================
  // apb decode
  logic        acc;
  logic        wr_en;
  logic        sel_psc;
  logic        sel_mode;
  logic        sel_stat;
  logic        stp_set;
  logic [31:0] rd_mux;
  logic        unmapped;
  assign acc      = psel & penable;
  assign wr_en    = acc & pready_reg & pwrite & ~pslverr_reg;
  assign stp_set  = wr_en & sel_psc & pwdata[HLS_PSC_STP] & ~psc_reg[HLS_PSC_STP];
  always_comb
  begin
    sel_psc  = 1'b0;
    sel_mode = 1'b0;
    sel_stat = 1'b0;
    unmapped = 1'b0;
    if (paddr == HLS_OFS_PSC)
      sel_psc = 1'b1;
    else if (paddr == HLS_OFS_MODE)
      sel_mode = 1'b1;
    else if (paddr == HLS_OFS_STATUS)
      sel_stat = 1'b1;
    else
      unmapped = 1'b1;
  end
  always_comb
  begin
    rd_mux = '0;
    if (sel_psc)
      rd_mux[7:0] = psc_reg;
    else if (sel_mode)
      rd_mux[1:0] = mode_reg;
    else if (sel_stat)
      rd_mux[5:0] = {last_reg, state_reg};
  end
  // one wait state so read data leaves a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else if (acc && !pready_reg)
    begin
      pready_reg  <= 1'b1;
      prdata_reg  <= rd_mux;
      pslverr_reg <= unmapped;
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end
  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;
  // ==========================================================
  // power save control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      psc_reg <= HLS_PSC_RST;
    else if (soft_rst)
      psc_reg <= HLS_PSC_RST;
    else if (state_reg == ST_WAKE)
      psc_reg[HLS_PSC_STP] <= 1'b0;
    else if (wr_en && sel_psc)
    begin
      // masks written with the stop bit are not taken
      if (stp_set)
        psc_reg[HLS_PSC_STP] <= (mode_reg == HLS_KIND_LIGHT);
      else
        psc_reg <= pwdata[7:0] & HLS_PSC_WMSK;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= HLS_MODE_RST;
    else if (soft_rst)
      mode_reg <= HLS_MODE_RST;
    else if (wr_en && sel_mode)
      mode_reg <= pwdata[1:0];
  end
  // ==========================================================
  // state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (stp_set && mode_reg == HLS_KIND_LIGHT)
          state_next = ST_IDLE;
        else if (cpu_halt_exec)
          state_next = ST_HALT;
      end
      ST_HALT:
      begin
        if (wake_c)
          state_next = ST_WAKE;
      end
      ST_IDLE:
      begin
        if (wake_c)
          state_next = ST_WAKE;
      end
      ST_WAKE:
        state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= ST_RUN;
    else if (soft_rst)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end
  // ==========================================================
  // resume actions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_reg <= '0;
    else if (soft_rst)
      act_reg <= '0;
    else if (in_stby && wake_c)
      act_reg <= act_c;
    else
      act_reg <= '0;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_reg <= '0;
    else if (soft_rst)
      last_reg <= '0;
    else if (in_stby && wake_c)
      last_reg <= act_c;
  end
  assign resume        = act_reg;
  assign sys_reset_req = soft_rst;
  // ==========================================================
  // clock enables
  hls_clk_en_t clk_en_next;
  hls_clk_en_t clk_en_reg;
  logic        stby_next;
  logic        hold_reg;
  // decoded from the next state into flops: wake to run flips two state
  // bits at once, a direct decode could glitch the gates
  always_comb
  begin
    clk_en_next               = '1;
    clk_en_next.osc_pll_flash = 1'b1;
    clk_en_next.subclk_periph = 1'b1;
    case (state_next)
      ST_HALT:
      begin
        clk_en_next.cpu     = 1'b0;
        clk_en_next.timer_m = subclock_used | ~tmm_clk_is_subclk;
        clk_en_next.watch   = subclock_used | watch_clk_is_baud;
      end
      ST_IDLE:
      begin
        clk_en_next.cpu     = 1'b0;
        clk_en_next.periph  = 1'b0;
        clk_en_next.dma     = 1'b0;
        clk_en_next.timer_m = tmm_clk_is_intosc | (subclock_used & tmm_clk_is_subclk);
        clk_en_next.watch   = subclock_used | watch_clk_is_baud;
      end
      default:
        clk_en_next = '1;
    endcase
  end
  assign stby_next = (state_next == ST_HALT) | (state_next == ST_IDLE);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_en_reg <= '1;
      hold_reg   <= 1'b0;
    end
    else if (soft_rst)
    begin
      clk_en_reg <= '1;
      hold_reg   <= 1'b0;
    end
    else
    begin
      clk_en_reg <= clk_en_next;
      hold_reg   <= stby_next;
    end
  end
  assign clk_en = clk_en_reg;
  // cpu state is simply frozen by its gated clock
  assign port_hold  = hold_reg;
  assign ram_retain = hold_reg;
endmodule : hls_standby_ctrl

/* verification/hls_props.sv */
// checker on the standby controller ports
// assumes bind into hls_standby_ctrl, one pclk domain
`timescale 1ns/100ps
module hls_props
  import hls_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // inputs watched
  input wire logic        cpu_halt_exec,
  input wire logic        watchdog_overflow_irq,
  input wire logic        subclock_used,
  input wire logic        tmm_clk_is_subclk,
  input wire logic        tmm_clk_is_intosc,
  input wire logic        watch_clk_is_baud,
  // outputs watched
  input wire hls_clk_en_t clk_en,
  input wire logic        port_hold,
  input wire logic        ram_retain,
  input wire logic        sys_reset_req,
  input wire hls_action_t resume
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========
  // entry and wake
  property p_halt;
    cpu_halt_exec && clk_en.cpu && resume == 4'h0 && !sys_reset_req |=> !clk_en.cpu && clk_en.periph;
  endproperty
  a_halt: assert property (p_halt) else $error("halt entry wrong");
  property p_wake;
    !clk_en.cpu && clk_en.periph && watchdog_overflow_irq && !sys_reset_req |=> resume.nmi;
  endproperty
  a_wake: assert property (p_wake) else $error("halt not left");
  property p_res;
    resume != 4'h0 |-> clk_en.cpu ##1 resume == 4'h0;
  endproperty
  a_res: assert property (p_res) else $error("resume not one cycle");
  property p_low;
    resume.next |-> !resume.ack && !resume.nmi;
  endproperty
  a_low: assert property (p_low) else $error("pending wake acked");
  // ========
  // clocks and retention
  property p_hold;
    !clk_en.cpu |-> port_hold && ram_retain;
  endproperty
  a_hold: assert property (p_hold) else $error("retention lost");
  property p_tm_h;
    !clk_en.cpu && clk_en.periph |-> clk_en.timer_m == (subclock_used | !tmm_clk_is_subclk)
      && clk_en.watch == (subclock_used | watch_clk_is_baud);
  endproperty
  a_tm_h: assert property (p_tm_h) else $error("halt timer clocks");
  property p_tm_i;
    !clk_en.periph |-> !clk_en.cpu && clk_en.osc_pll_flash
      && clk_en.timer_m == (tmm_clk_is_intosc | (subclock_used & tmm_clk_is_subclk));
  endproperty
  a_tm_i: assert property (p_tm_i) else $error("idle clocks");
  property p_rst;
    sys_reset_req |-> ##[1:2] clk_en == 7'h7f && !port_hold;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not ordinary");
endmodule : hls_props

bind hls_standby_ctrl hls_props u_props (.pclk(pclk), .presetn(presetn), .cpu_halt_exec(cpu_halt_exec),
  .watchdog_overflow_irq(watchdog_overflow_irq), .subclock_used(subclock_used),
  .tmm_clk_is_subclk(tmm_clk_is_subclk), .tmm_clk_is_intosc(tmm_clk_is_intosc),
  .watch_clk_is_baud(watch_clk_is_baud), .clk_en(clk_en), .port_hold(port_hold), .ram_retain(ram_retain),
  .sys_reset_req(sys_reset_req), .resume(resume));

/* verification/hls_cpu_model.sv */
// cpu core stand-in that issues halt instructions
// assumes the bench asks for a halt with a one cycle halt_go
`timescale 1ns/100ps
module hls_cpu_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench and controller
  input  wire logic halt_go,
  output logic      cpu_halt_exec
);
  logic [2:0] gap_reg;
  // ========
  // halt issue; nop slots block a new halt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_halt_exec <= 1'b0;
      gap_reg       <= 3'h0;
    end
    else if (halt_go && gap_reg == 3'h0)
    begin
      cpu_halt_exec <= 1'b1;
      gap_reg       <= 3'h5;
    end
    else
    begin
      cpu_halt_exec <= 1'b0;
      gap_reg       <= (gap_reg == 3'h0) ? 3'h0 : gap_reg - 3'h1;
    end
  end
endmodule : hls_cpu_model

/* verification/hls_tb.sv */
// self-checking bench for the standby controller
// assumes hls_cpu_model as cpu and the bound checker
`timescale 1ns/100ps
module testbench;
  import hls_pkg::*;
  typedef struct packed {
    logic       idle;
    logic       pre;
    logic [1:0] src;
    logic       en;
    logic       svc;
    logic [2:0] pend;
    logic [2:0] serv;
    logic [3:0] sel;
    logic [3:0] exp;
  } hls_row_t;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, irq_enabled_state, in_service, halt_go;
  logic        nmi_pin, watchdog_overflow_irq, cpu_halt_exec, pready, pslverr, port_hold;
  logic        ram_retain, sys_reset_req, er, tm;
  logic [7:0]  paddr, periph_irqs, per_um;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] external_pin_irqs, pin_um;
  logic [2:0]  pend_prio, serv_prio, e3;
  logic [4:0]  rs;
  logic [3:0]  sel;
  hls_clk_en_t clk_en;
  hls_action_t resume, res;
  hls_row_t    rows [8];
  hls_row_t    r;
  int          bad_count, total_checks, k;
  always #25 pclk = ~pclk;
  hls_standby_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_halt_exec(cpu_halt_exec), .irq_enabled_state(irq_enabled_state), .nmi_pin(nmi_pin),
    .watchdog_overflow_irq(watchdog_overflow_irq), .external_pin_irqs(external_pin_irqs),
    .pin_irq_unmask(pin_um), .periph_irqs(periph_irqs), .periph_irq_unmask(per_um),
    .pend_prio(pend_prio), .serv_prio(serv_prio), .in_service(in_service),
    .clk_en(clk_en), .port_hold(port_hold), .ram_retain(ram_retain), .sys_reset_req(sys_reset_req),
    .resume(resume),
    .reset_pin_n(~rs[0]), .watchdog_reset_req(rs[1]), .power_on_clear(rs[2]),
    .low_voltage_detect(rs[3]), .clock_monitor_reset(rs[4]), .subclock_used(sel[3]),
    .tmm_clk_is_subclk(sel[2]), .tmm_clk_is_intosc(sel[1]), .watch_clk_is_baud(sel[0]));
  hls_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .halt_go(halt_go), .cpu_halt_exec(cpu_halt_exec));
  // ========
  // tasks
  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : apb
  // bounded wait: 0 cpu stopped, 1 resume, 2 reset, 3 idle
  task automatic wt(input int c);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(negedge pclk);
      if ((c == 0 && clk_en.cpu === 1'b0) || (c == 1 && resume !== 4'h0)
          || (c == 2 && sys_reset_req === 1'b1) || (c == 3 && clk_en.periph === 1'b0))
        break;
    end
    res = resume;
    if (i == 40)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : wt
  task automatic do_halt();
    @(posedge pclk);
    halt_go <= 1'b1;
    @(posedge pclk);
    halt_go <= 1'b0;
  endtask : do_halt
  task automatic src_set(input logic [1:0] s, input logic v);
    @(posedge pclk);
    case (s)
      2'h0: nmi_pin <= v;
      2'h1: watchdog_overflow_irq <= v;
      2'h2: external_pin_irqs[10] <= v;
      default: periph_irqs[0] <= v;
    endcase
  endtask : src_set
  // ========
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, irq_enabled_state, in_service, halt_go} = 7'h0;
    {nmi_pin, watchdog_overflow_irq, paddr, periph_irqs, pwdata} = 50'h0;
    {external_pin_irqs, pend_prio, serv_prio, rs, sel} = 26'h0;
    {pin_um, per_um} = 19'h7ffff;
    rows = '{'{1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 3'h0, 3'h0, 4'h0, 4'h8},
             '{1'h0, 1'h1, 2'h1, 1'h0, 1'h0, 3'h0, 3'h0, 4'h4, 4'hc},
             '{1'h0, 1'h0, 2'h2, 1'h1, 1'h0, 3'h0, 3'h0, 4'h1, 4'h2},
             '{1'h0, 1'h0, 2'h3, 1'h1, 1'h1, 3'h1, 3'h3, 4'hc, 4'h2},
             '{1'h0, 1'h0, 2'h3, 1'h1, 1'h1, 3'h5, 3'h2, 4'h0, 4'h1},
             '{1'h1, 1'h0, 2'h2, 1'h0, 1'h0, 3'h0, 3'h0, 4'h2, 4'h1},
             '{1'h1, 1'h1, 2'h3, 1'h1, 1'h0, 3'h0, 3'h0, 4'hc, 4'h2},
             '{1'h1, 1'h0, 2'h1, 1'h1, 1'h1, 3'h3, 3'h1, 4'ha, 4'hc}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'(k * 4), 32'h0);
      check("reset read", 32'h0, rd);
      check("slave error", {31'h0, k == 3}, {31'h0, er});
    end
    for (k = 0; k < 8; k++)
    begin
      r = rows[k];
      apb(1'b1, HLS_OFS_PSC, r.idle ? 32'h0 : 32'h70);
      @(posedge pclk);
      sel               <= r.sel;
      irq_enabled_state <= r.en;
      in_service        <= r.svc;
      pend_prio         <= r.pend;
      serv_prio         <= r.serv;
      if (r.pre)
        src_set(r.src, 1'b1);
      if (r.idle)
        apb(1'b1, HLS_OFS_PSC, 32'h2);
      else
        do_halt();
      if (!r.pre)
      begin
        wt(0);
        tm = r.idle ? (r.sel[1] | (r.sel[3] & r.sel[2])) : (r.sel[3] | ~r.sel[2]);
        e3 = {~r.idle, tm, r.sel[3] | r.sel[0]};
        check("standby clk", {28'h0, ~r.idle, e3},
              {28'h0, clk_en.dma, clk_en.periph, clk_en.timer_m, clk_en.watch});
        check("retention", 32'h3, {30'h0, port_hold, ram_retain});
        src_set(r.src, 1'b1);
      end
      wt(1);
      check("resume", {28'h0, r.exp}, {28'h0, res});
      src_set(r.src, 1'b0);
      repeat (8) @(posedge pclk);
      apb(1'b0, HLS_OFS_STATUS, 32'h0);
      check("status", {26'h0, r.exp, 2'h0}, rd);
    end
    // other kinds ignore the stop bit; reserved bits read 0
    apb(1'b1, HLS_OFS_MODE, 32'h1);
    apb(1'b1, HLS_OFS_PSC, 32'hfd);
    apb(1'b1, HLS_OFS_PSC, 32'hff);
    apb(1'b0, HLS_OFS_PSC, 32'h0);
    check("psc read", 32'h70, rd);
    @(negedge pclk);
    check("no entry", 32'h1, {31'h0, clk_en.cpu});
    apb(1'b0, HLS_OFS_MODE, 32'h0);
    check("mode read", 32'h1, rd);
    apb(1'b1, HLS_OFS_MODE, 32'h0);
    apb(1'b1, HLS_OFS_PSC, 32'h40);
    apb(1'b1, HLS_OFS_PSC, 32'h42);
    repeat (5) @(posedge pclk);
    wt(3);
    src_set(2'h1, 1'b1);
    repeat (10) @(negedge pclk);
    check("masked wake", 32'h0, {31'h0, clk_en.periph});
    src_set(2'h0, 1'b1);
    wt(1);
    check("nmi wake", 32'h8, {28'h0, res});
    src_set(2'h0, 1'b0);
    src_set(2'h1, 1'b0);
    // masked pin and peripheral requests keep halt; masked watchdog still wakes
    pin_um <= 11'h3ff;
    per_um <= 8'hfe;
    do_halt();
    wt(0);
    src_set(2'h2, 1'b1);
    src_set(2'h3, 1'b1);
    repeat (10) @(negedge pclk);
    check("masked irq", 32'h0, {31'h0, clk_en.cpu});
    src_set(2'h1, 1'b1);
    wt(1);
    check("wdt wake", 32'hc, {28'h0, res});
    src_set(2'h1, 1'b0);
    src_set(2'h2, 1'b0);
    src_set(2'h3, 1'b0);
    pin_um <= 11'h7ff;
    per_um <= 8'hff;
    // every reset source from halt
    for (k = 0; k < 5; k++)
    begin
      apb(1'b1, HLS_OFS_PSC, 32'h70);
      do_halt();
      wt(0);
      @(posedge pclk);
      rs[k] <= 1'b1;
      wt(2);
      @(negedge pclk);
      check("reset clk", 32'h7f, {25'h0, clk_en});
      @(posedge pclk);
      rs[k] <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, HLS_OFS_PSC, 32'h0);
      check("reset psc", 32'h0, rd);
    end
    report_and_stop();
  end
endmodule : testbench
